// [logic/sabc_approx_reg.sv]
`timescale 1ns/100ps
`default_nettype none

module sabc_approx_reg
    import sabc_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clear_i,
    input  wire logic        step_i,
    input  wire logic [7:0]  bit_mask_i,
    input  wire logic        cmp_i,
    output logic      [7:0]  approx_o,
    output logic      [7:0]  trial_o
);

    logic [7:0] approx_q;
    logic [7:0] approx_d;

    // ------------------------------------------------------------
    // next value
    // ------------------------------------------------------------
    always_comb begin
        approx_d = approx_q;
        if (clear_i) begin
            approx_d = ZERO_CODE;
        end else if (step_i) begin
            // a low comparator leaves the bit clear, so vin- >= vin+ ends at zero
            approx_d = sabc_decide(approx_q, bit_mask_i, cmp_i);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            approx_q <= ZERO_CODE;
        end else begin
            approx_q <= approx_d;
        end
    end

    assign approx_o = approx_q;
    assign trial_o  = approx_q | bit_mask_i;

endmodule

`default_nettype wire

// [logic/sabc_ctrl.sv]
// Notes on behaviour
// - resolve msb first, 8 comparisons over 64 conversion clocks.
// - final result is straight binary into output latch, all ones full scale.
// - start falling edge clears approximation, token stages, done output high.
// - while chip select and start both low, stay in reset.
// - conversion begins 1 to 4 system clocks (0.5 to 2 conversion clocks) after start releases.
// - done output goes low when conversion completes.
// - read with chip select low returns done output high.
// - free running with chip select low and done fed to start.
// - new start during conversion aborts and restarts from reset.
// - start condition sets start flop, resets tokens, clears done, feeds entry.
// - start flop cleared after entry captures one, only if start removed.
// - token leaving last stage copies word to output latch.
// - next clock exit stage sets done flag; done output is its inverse.
// - chip select and read low clear done flag and enable outputs.
// - chip select, start and read are all active low.
// - positive and negative inputs sampled 4.5 conversion clocks apart.
// - negative input at or above positive gives all-zero code.
// - long start low holds reset; rising edge starts conversion.
`timescale 1ns/100ps
`default_nettype none

module sabc_ctrl
    import sabc_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic              cs_n_i,
    input  wire logic              start_n_i,
    input  wire logic              rd_n_i,
    input  wire logic              cmp_i,
    output logic      [DATA_W-1:0] trial_code_o,
    output logic                   sample_pos_o,
    output logic                   sample_neg_o,
    output logic      [DATA_W-1:0] data_o,
    output logic                   data_oe_o,
    output logic                   done_flag_n_o,
    output logic                   busy_o
);

    // ------------------------------------------------------------
    // bus conditions
    // ------------------------------------------------------------
    logic start_cond;
    logic read_cond;

    assign start_cond = !cs_n_i && !start_n_i;
    assign read_cond  = !cs_n_i && !rd_n_i;

    // ------------------------------------------------------------
    // conversion clock divider
    // ------------------------------------------------------------
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic             conv_tick;

    assign conv_tick = (div_q == DIV_LAST);

    always_comb begin
        div_d = conv_tick ? '0 : div_q + DIV_W'(1);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    sabc_state_t        st_q;
    logic               start_q;
    logic [STAGES-1:0]  tok_q;
    logic               exit_q;
    logic [HALF_W-1:0]  half_q;
    logic               done_q;
    logic [DATA_W-1:0]  result_q;
    logic               sar_clear;
    logic               sar_step;
    logic               start_clear_gate;
    logic               latch_transfer_gate;
    logic               decide;
    logic [DATA_W-1:0]  bit_mask;
    logic [DATA_W-1:0]  approx;
    logic               token_entry_stage;
    logic               token_exit_stage;

    // true only in the conversion state, at one step of the bit period
    function automatic logic at_step(input sabc_state_t       st,
                                     input logic [HALF_W-1:0] half,
                                     input logic [HALF_W-1:0] step);
        return (st == SABC_CONV) && (half == step);
    endfunction

    assign token_entry_stage = tok_q[0];
    assign token_exit_stage  = exit_q;
    assign bit_mask          = sabc_token_mask(tok_q);
    assign decide            = at_step(st_q, half_q, DECIDE_STEP);

    // entry stage holds its one while the flop is set; clear only once released
    assign start_clear_gate    = start_q && token_entry_stage && conv_tick
                                 && !start_cond;
    assign latch_transfer_gate = decide && tok_q[STAGES-1];

    // a start overrides every strobe, so an abort leaves nothing half done
    assign sar_clear = start_cond && !start_q;
    assign sar_step  = !start_cond && decide;

    // ------------------------------------------------------------
    // start flop
    // ------------------------------------------------------------
    logic start_d;

    always_comb begin
        start_d = start_q;
        if (start_cond) begin
            // start flop set: tokens reset, done cleared, entry fed a one
            start_d = 1'b1;
        end else if ((st_q == SABC_HOLD) && start_clear_gate) begin
            start_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_d;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    sabc_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (start_cond) begin
            st_d = SABC_HOLD;
        end else begin
            case (st_q)
                SABC_IDLE: begin
                    st_d = SABC_IDLE;
                end
                SABC_HOLD: begin
                    if (start_clear_gate) begin
                        st_d = SABC_CONV;
                    end
                end
                SABC_CONV: begin
                    if (latch_transfer_gate) begin
                        st_d = SABC_XFER;
                    end
                end
                SABC_XFER: begin
                    st_d = SABC_IDLE;
                end
                default: begin
                    st_d = SABC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q <= SABC_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // token shift register
    // ------------------------------------------------------------
    logic [STAGES-1:0] tok_d;

    always_comb begin
        tok_d = tok_q;
        if (start_cond) begin
            if (!start_q) begin
                // first low cycle: everything back to reset
                tok_d = '0;
            end else begin
                tok_d = {{(STAGES-1){1'b0}}, tok_q[0] | conv_tick};
            end
        end else begin
            case (st_q)
                SABC_HOLD: begin
                    if (conv_tick && !token_entry_stage) begin
                        tok_d[0] = 1'b1;
                    end
                end
                SABC_CONV: begin
                    if (decide) begin
                        tok_d = tok_q << 1;
                    end
                end
                default: begin
                    tok_d = tok_q;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tok_q <= '0;
        end else begin
            tok_q <= tok_d;
        end
    end

    // ------------------------------------------------------------
    // exit stage
    // ------------------------------------------------------------
    logic exit_d;

    always_comb begin
        exit_d = 1'b0;
        if (!start_cond && latch_transfer_gate) begin
            exit_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            exit_q <= 1'b0;
        end else begin
            exit_q <= exit_d;
        end
    end

    // ------------------------------------------------------------
    // half-step counter
    // ------------------------------------------------------------
    logic [HALF_W-1:0] half_d;

    always_comb begin
        half_d = half_q;
        if (start_cond) begin
            half_d = '0;
        end else begin
            case (st_q)
                SABC_HOLD: begin
                    if (start_clear_gate) begin
                        half_d = '0;
                    end
                end
                SABC_CONV: begin
                    // wraps once per bit period, so no reload between bits
                    half_d = half_q + HALF_W'(1);
                end
                default: begin
                    half_d = half_q;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            half_q <= '0;
        end else begin
            half_q <= half_d;
        end
    end

    // ------------------------------------------------------------
    // done flag
    // ------------------------------------------------------------
    logic done_d;

    always_comb begin
        done_d = done_q;
        // read clears the flag; a set later in this process wins
        if (read_cond) begin
            done_d = 1'b0;
        end
        if (start_cond) begin
            done_d = 1'b0;
        end else if (st_q == SABC_XFER) begin
            done_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    // ------------------------------------------------------------
    // result latch
    // ------------------------------------------------------------
    logic [DATA_W-1:0] result_d;

    always_comb begin
        result_d = result_q;
        if (!start_cond && latch_transfer_gate) begin
            // last bit decided in the same edge as the copy
            result_d = sabc_decide(approx, bit_mask, cmp_i);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            result_q <= ZERO_CODE;
        end else begin
            result_q <= result_d;
        end
    end

    // ------------------------------------------------------------
    // approximation register
    // ------------------------------------------------------------
    sabc_approx_reg u_approx (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .clear_i    (sar_clear),
        .step_i     (sar_step),
        .bit_mask_i (bit_mask),
        .cmp_i      (cmp_i),
        .approx_o   (approx),
        .trial_o    (trial_code_o)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // half-step counter gives the half period needed for the 4.5 gap
    assign sample_pos_o  = at_step(st_q, half_q, POS_SAMPLE_STEP);
    assign sample_neg_o  = at_step(st_q, half_q, NEG_SAMPLE_STEP);
    assign done_flag_n_o = !done_q;
    assign data_o        = result_q;
    assign data_oe_o     = read_cond;
    assign busy_o        = (st_q != SABC_IDLE) || token_exit_stage;

endmodule

`default_nettype wire

// [logic/sabc_pkg.sv]
package sabc_pkg;

    // ------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned STAGES     = 8;
    localparam logic [7:0]  FULL_SCALE = 8'hFF;
    localparam logic [7:0]  ZERO_CODE  = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_NS     = 50;
    localparam int unsigned CONV_CLK_NS    = 100;
    localparam int unsigned CONV_DIV       = CONV_CLK_NS / SYS_CLK_NS;
    localparam int unsigned CONV_PER_BIT   = 8;
    localparam int unsigned CONV_TOTAL     = 64;
    localparam int unsigned SAMPLE_GAP_X10 = 45;
    localparam int unsigned HALF_PER_BIT   = CONV_PER_BIT * CONV_DIV;
    localparam int unsigned HALF_W         = $clog2(HALF_PER_BIT);
    localparam int unsigned DIV_W          = (CONV_DIV > 1) ? $clog2(CONV_DIV) : 1;
    localparam logic [HALF_W-1:0] POS_SAMPLE_STEP = '0;
    localparam logic [HALF_W-1:0] NEG_SAMPLE_STEP =
        HALF_W'((SAMPLE_GAP_X10 * CONV_DIV) / 10);
    localparam logic [HALF_W-1:0] DECIDE_STEP = HALF_W'(HALF_PER_BIT - 1);
    localparam logic [DIV_W-1:0]  DIV_LAST    = DIV_W'(CONV_DIV - 1);

    // ------------------------------------------------------------
    // control states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SABC_IDLE,
        SABC_HOLD,
        SABC_CONV,
        SABC_XFER
    } sabc_state_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // token stage k tests code bit (msb - k)
    function automatic logic [7:0] sabc_token_mask(input logic [7:0] tok);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[7-i] = tok[i];
        end
        return m;
    endfunction

    function automatic logic [7:0] sabc_decide(input logic [7:0] approx,
                                               input logic [7:0] mask,
                                               input logic       keep);
        return keep ? (approx | mask) : approx;
    endfunction

endpackage

// [test/sabc_chk.sv]
`timescale 1ns/100ps
`default_nettype none
// ----
// port checker
// ----
module sabc_chk
    import sabc_pkg::*;
(
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire logic              cs_n_i,
    input wire logic              start_n_i,
    input wire logic              rd_n_i,
    input wire logic              sample_pos_o,
    input wire logic              sample_neg_o,
    input wire logic [DATA_W-1:0] trial_code_o,
    input wire logic              data_oe_o,
    input wire logic              done_flag_n_o,
    input wire logic              busy_o
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       go;
    assign go = !cs_n_i && !start_n_i;
    always_comb begin
        cnt_d = cnt_q;
        if (go) begin
            cnt_d = 4'h0;
        end else if (sample_pos_o) begin
            cnt_d = cnt_q + 4'h1;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        cnt_q <= rst_i ? 4'h0 : cnt_d;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    out_enable_a: assert property (data_oe_o == (!cs_n_i && !rd_n_i))
        else $error("output enable mismatch");
    neg_gap_a: assert property (sample_pos_o |-> ##9 sample_neg_o)
        else $error("negative sample spacing");
    start_clr_a: assert property (go |=> done_flag_n_o)
        else $error("start left done asserted");
    hold_reset_a: assert property (go |=> !sample_pos_o)
        else $error("converting while start held");
    start_lat_a: assert property ($past(go) && !go |-> ##[1:16] sample_pos_o)
        else $error("conversion did not begin in time");
    eight_bits_a: assert property ($fell(done_flag_n_o) |-> cnt_q == 4'h8)
        else $error("done without eight comparisons");
    done_lat_a: assert property (sample_pos_o && cnt_q == 4'h7 |-> ##[16:20] !done_flag_n_o)
        else $error("done late after last bit");
    read_clr_a: assert property (!cs_n_i && !rd_n_i && !done_flag_n_o |=> done_flag_n_o)
        else $error("read did not clear done");
    done_keep_a: assert property (!done_flag_n_o && (cs_n_i || (rd_n_i && start_n_i))
        |=> !done_flag_n_o)
        else $error("done dropped without cause");
    msb_first_a: assert property (sample_pos_o && cnt_q == 4'h0 |-> trial_code_o == 8'h80)
        else $error("first trial not msb");
    busy_start_a: assert property ($rose(busy_o) |-> $past(go))
        else $error("busy without a start");
endmodule
bind sabc_ctrl sabc_chk i_chk (.sys_clk_i, .rst_i, .cs_n_i, .start_n_i, .rd_n_i,
    .sample_pos_o, .sample_neg_o, .trial_code_o, .data_oe_o, .done_flag_n_o, .busy_o);
`default_nettype wire

// [test/sabc_front.sv]
`timescale 1ns/100ps
`default_nettype none
// ----
// analog front end stand-in
// ----
module sabc_front (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] pos_i,
    input  wire logic [7:0] neg_i,
    input  wire logic       sample_pos_i,
    input  wire logic       sample_neg_i,
    input  wire logic [7:0] trial_i,
    output logic            cmp_o
);
    logic [7:0] pos_q;
    logic [7:0] neg_q;
    // held between samples, so input drift only shows at the sample pulses
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pos_q <= 8'h00;
            neg_q <= 8'h00;
        end else begin
            if (sample_pos_i) pos_q <= pos_i;
            if (sample_neg_i) neg_q <= neg_i;
        end
    end
    assign cmp_o = (pos_q > neg_q) && ((pos_q - neg_q) >= trial_i);
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
// ----
// bench
// ----
module testbench;
    import sabc_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        cs_n      = 1'b1;
    logic        start_q   = 1'b1;
    logic        rd_n      = 1'b1;
    logic        free_run  = 1'b0;
    logic        oe_prev   = 1'b0;
    logic [7:0]  pos       = 8'h00;
    logic [7:0]  neg       = 8'h00;
    logic [7:0]  trial;
    logic [7:0]  data;
    logic        cmp;
    logic        sp;
    logic        sn;
    logic        oe;
    logic        done_n;
    logic        busy;
    logic [31:0] rnd = 32'h0000005D;
    logic [7:0]  exp_q[$];
    int          error_cnt       = 0;
    int          samples_checked = 0;
    int          cycles          = 0;
    wire logic   start_n;
    // free running feeds done straight back into start
    assign start_n = free_run ? done_n : start_q;
    sabc_ctrl i_dut (.sys_clk_i, .rst_i, .cs_n_i(cs_n), .start_n_i(start_n), .rd_n_i(rd_n),
        .cmp_i(cmp), .trial_code_o(trial), .sample_pos_o(sp), .sample_neg_o(sn),
        .data_o(data), .data_oe_o(oe), .done_flag_n_o(done_n), .busy_o(busy));
    sabc_front i_front (.sys_clk_i, .rst_i, .pos_i(pos), .neg_i(neg), .sample_pos_i(sp),
        .sample_neg_i(sn), .trial_i(trial), .cmp_o(cmp));
    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask
    task automatic wait_done();
        while (done_n !== 1'b0) tick(1);
    endtask
    task automatic start(input int w);
        cs_n = 1'b0;
        start_q = 1'b0;
        tick(w);
        check_flag(done_n, 1'b1, "done in start");
        check_flag(busy, 1'b1, "busy in start");
        start_q = 1'b1;
        cs_n = 1'b1;
        tick(1);
    endtask
    task automatic rd();
        cs_n = 1'b0;
        rd_n = 1'b0;
        tick(2);
        rd_n = 1'b1;
        cs_n = 1'b1;
        check_flag(done_n, 1'b1, "done after read");
        check_flag(busy, 1'b0, "busy after read");
        tick(1);
    endtask
    task automatic conv(input logic [7:0] p, input logic [7:0] n, input int w);
        pos = p;
        neg = n;
        start(w);
        wait_done();
        exp_q.push_back((p > n) ? p - n : 8'h00);
        rd();
    endtask
    // results show when the outputs turn on; stray enables find an empty queue
    always @(posedge sys_clk_i) begin
        if (oe === 1'b1 && oe_prev !== 1'b1) begin
            if (exp_q.size() == 0) check8(data, 8'hXX, "unexpected enable");
            else check8(data, exp_q.pop_front(), "result");
        end
        oe_prev <= oe;
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk_i);
        #2;
        rst_i = 1'b0;
        tick(1);
        conv(8'hFF, 8'h00, 3);
        conv(8'h00, 8'h00, 1);
        conv(8'h40, 8'h80, 40);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            conv(rnd[7:0], rnd[15:8] >> 2, 1 + int'(rnd[18:16]));
        end
        pos = 8'hC3;
        start(3);
        tick(60);
        conv(8'h5A, 8'h00, 3);
        rd_n = 1'b0;
        tick(3);
        rd_n = 1'b1;
        pos = 8'h21;
        cs_n = 1'b0;
        start_q = 1'b0;
        tick(2);
        start_q = 1'b1;
        free_run = 1'b1;
        repeat (2) begin
            wait_done();
            tick(1);
        end
        free_run = 1'b0;
        wait_done();
        exp_q.push_back(8'h21);
        rd();
        tick(5);
        end_of_test();
    end
endmodule
`default_nettype wire
